// ===== design/ssdc_core.sv
// Selection decoder, role flags, SCSI drive gating and host register file.
// Assumes a Wishbone classic master and a sequencer port in the same clock domain.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "ssdc_params.svh"
module ssdc_core #(
  parameter int QDEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  own_id,
  input  wire logic        sel_valid,
  input  wire ssdc_pkg::ssdc_sel_kind_t sel_kind,
  input  wire logic [15:0] scsi_data_in,
  input  wire logic        scsi_par_lo,
  input  wire logic        scsi_par_hi,
  input  wire logic        seq_status_done,
  input  wire logic [7:0]  seq_status_byte,
  input  wire logic        seq_no_block,
  input  wire logic        seq_linked_done,
  input  wire logic        seq_q_push,
  input  wire logic [7:0]  seq_q_data,
  input  wire logic        seq_sync_done,
  input  wire logic        seq_sync_fast,
  input  wire logic        seq_bus_free,
  output logic             seq_halt,
  output logic             abort_msg_req,
  output logic             sel_respond,
  output logic [15:0]      scsi_data_out,
  output logic [15:0]      scsi_data_oe,
  output logic             bsy_oe,
  output logic             sel_oe,
  output logic             req_oe,
  output logic             ack_oe,
  output logic             cd_oe,
  output logic             io_oe,
  output logic             msg_oe,
  output logic             io_dir
);
  initial begin
    if (QDEPTH < 2 || QDEPTH > 256) $error("QDEPTH out of range");
    // Queue pointers wrap by overflow, so only powers of two are served
    if ((QDEPTH & (QDEPTH - 1)) != 0) $error("QDEPTH must be a power of two");
  end

  localparam int QW = $clog2(QDEPTH);

  logic [7:0]  hctl;
  logic [1:0]  thr;
  logic [3:0]  id_grp;
  logic [2:0]  arbsel;
  logic        init_flag;
  logic        targ_flag;
  logic [3:0]  istat;
  logic [4:0]  phase;
  logic [7:0]  qmem [QDEPTH];
  logic [QW-1:0] q_rd;
  logic [QW-1:0] q_wr;
  logic [QW:0]   q_cnt;

  // Bus access decode
  wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr      = req & wb_we_i & wb_sel_i[0];
  wire rd      = req & ~wb_we_i;
  wire wr_hctl = wr && (wb_adr_i == `SSDC_A_HCTL);
  wire wr_id   = wr && (wb_adr_i == `SSDC_A_ID);
  wire wr_as   = wr && (wb_adr_i == `SSDC_A_ARBSEL);
  wire wr_icl  = wr && (wb_adr_i == `SSDC_A_ICLR);
  wire wr_ph   = wr && (wb_adr_i == `SSDC_A_PHASE);
  wire rd_q    = rd && (wb_adr_i == `SSDC_A_QOUT) && (q_cnt != '0);

  // Selection pattern decode
  wire [4:0] n_lo = 5'($countones(scsi_data_in[7:0]));
  wire [4:0] n_hi = 5'($countones(scsi_data_in[15:8]));
  wire comb_a = (n_lo == 5'h0) && scsi_par_lo && (n_hi == 5'h2) && scsi_par_hi;
  wire comb_b = (n_lo == 5'h1) && !scsi_par_lo
              && (((n_hi == 5'h1) && !scsi_par_hi) || (n_hi == 5'h0));
  wire comb_c = (n_lo == 5'h2) && scsi_par_lo && (n_hi == 5'h0);
  wire pat_ok = comb_a | comb_b | comb_c;
  wire sel_good = sel_valid & pat_ok;

  wire set_init = sel_good && (sel_kind == ssdc_pkg::SSDC_SEL_OUT
                            || sel_kind == ssdc_pkg::SSDC_RESEL_IN);
  wire set_targ = sel_good && (sel_kind == ssdc_pkg::SSDC_SEL_IN
                            || sel_kind == ssdc_pkg::SSDC_RESEL_OUT);

  wire [1:0] thr_dflt = hctl[`SSDC_HC_MODE] ? `SSDC_THR_MODE_B : `SSDC_THR_MODE_A;
  wire nonzero_st = seq_status_done && (seq_status_byte != 8'h00);

  // Events set over clear so none is lost in the cycle they are cleared
  wire [3:0] ev = {sel_good && sel_kind == ssdc_pkg::SSDC_SEL_IN,
                   seq_linked_done, seq_no_block, nonzero_st};
  wire [3:0] next_istat = (istat & ~(wr_icl ? wb_dat_i[3:0] : 4'h0)) | ev;

  wire [15:0] id_bit = 16'h0001 << id_grp;
  wire        role   = init_flag | targ_flag;

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (wb_adr_i == `SSDC_A_HCTL) begin
      rdata = {24'h0, hctl};
    end else if (wb_adr_i == `SSDC_A_HSTAT) begin
      rdata = {24'h0, thr, 6'h0};
    end else if (wb_adr_i == `SSDC_A_ID) begin
      rdata = {28'h0, id_grp};
    end else if (wb_adr_i == `SSDC_A_ARBSEL) begin
      rdata = {29'h0, arbsel};
    end else if (wb_adr_i == `SSDC_A_ROLE) begin
      rdata = {30'h0, targ_flag, init_flag};
    end else if (wb_adr_i == `SSDC_A_ISTAT) begin
      rdata = {28'h0, istat};
    end else if (wb_adr_i == `SSDC_A_QOUT) begin
      rdata = {24'h0, qmem[q_rd]};
    end else if (wb_adr_i == `SSDC_A_QCNT) begin
      rdata = {{(31-QW){1'b0}}, q_cnt};
    end else if (wb_adr_i == `SSDC_A_IDS) begin
      rdata = {`SSDC_DEVICE_ID, `SSDC_VENDOR_ID};
    end else if (wb_adr_i == `SSDC_A_PHASE) begin
      rdata = {27'h0, phase};
    end
  end

  // Host registers; sequencer reaches only thr via seq_sync_done in mode B, and host never halts for them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hctl <= 8'h0;
      thr  <= `SSDC_THR_MODE_A;
    end else begin
      if (wr_hctl) hctl <= wb_dat_i[7:0];
      if (wr_hctl) thr <= wb_dat_i[`SSDC_HC_MODE] ? `SSDC_THR_MODE_B : `SSDC_THR_MODE_A;
      else if (seq_sync_done && hctl[`SSDC_HC_MODE]) thr <= seq_sync_fast ? `SSDC_THR_FAST : thr_dflt;
    end
  end

  // Control groups
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      id_grp    <= 4'h0;
      arbsel    <= 3'h0;
      init_flag <= 1'b0;
      targ_flag <= 1'b0;
      phase     <= 5'h0;
    end else begin
      if (wr_id) id_grp <= own_id;
      if (wr_as) arbsel <= wb_dat_i[2:0];
      if (wr_ph) phase <= wb_dat_i[4:0];
      // A good selection wins over a bus-free clear in the same cycle
      if (set_init) begin
        init_flag <= 1'b1;
        targ_flag <= 1'b0;
      end else if (set_targ) begin
        targ_flag <= 1'b1;
        init_flag <= 1'b0;
      end else if (seq_bus_free) begin
        init_flag <= 1'b0;
        targ_flag <= 1'b0;
      end
    end
  end

  // Completion queue: sequencer pushes while host pops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_rd  <= '0;
      q_wr  <= '0;
      q_cnt <= '0;
      istat <= 4'h0;
    end else begin
      istat <= next_istat;
      if (seq_q_push && q_cnt != (QW+1)'(QDEPTH)) q_wr <= q_wr + QW'(1);
      if (rd_q) q_rd <= q_rd + QW'(1);
      q_cnt <= q_cnt + (QW+1)'(seq_q_push && q_cnt != (QW+1)'(QDEPTH)) - (QW+1)'(rd_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (seq_q_push && q_cnt != (QW+1)'(QDEPTH)) qmem[q_wr] <= seq_q_data;
  end

  // Outputs, all registered; indirect ports have no host path at all
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0;
      seq_halt      <= 1'b0;
      abort_msg_req <= 1'b0;
      sel_respond   <= 1'b0;
      scsi_data_out <= 16'h0;
      scsi_data_oe  <= 16'h0;
      bsy_oe        <= 1'b0;
      sel_oe        <= 1'b0;
      req_oe        <= 1'b0;
      ack_oe        <= 1'b0;
      cd_oe         <= 1'b0;
      io_oe         <= 1'b0;
      msg_oe        <= 1'b0;
      io_dir        <= 1'b0;
    end else begin
      wb_ack_o      <= req;
      wb_dat_o      <= rdata;
      // Halt is sticky until the host clears it through the control register
      seq_halt      <= nonzero_st | (wr_hctl ? wb_dat_i[`SSDC_HC_HALT] : seq_halt);
      abort_msg_req <= seq_no_block;
      sel_respond   <= sel_good;
      scsi_data_out <= id_bit;
      scsi_data_oe  <= arbsel[`SSDC_AS_ARB] ? id_bit : 16'h0;
      bsy_oe        <= arbsel[`SSDC_AS_BSY];
      sel_oe        <= arbsel[`SSDC_AS_SEL];
      req_oe        <= targ_flag & phase[0];
      ack_oe        <= init_flag & phase[1];
      cd_oe         <= targ_flag & phase[2];
      msg_oe        <= targ_flag & phase[4];
      io_dir        <= phase[3];
      io_oe         <= role & phase[3];
    end
  end
  // Linked completion lands in the link event bit (bit 2) via ev above.
endmodule

// ===== design/ssdc_params.svh
// Constants for the selection validation and drive control block.
// Assumes a Wishbone classic slave with 32-bit data, byte addresses.
`ifndef SSDC_PARAMS_SVH
`define SSDC_PARAMS_SVH
`define SSDC_A_HCTL     6'h00
`define SSDC_A_HSTAT    6'h04
`define SSDC_A_ID       6'h08
`define SSDC_A_ARBSEL   6'h0c
`define SSDC_A_ROLE     6'h10
`define SSDC_A_ISTAT    6'h14
`define SSDC_A_ICLR     6'h18
`define SSDC_A_QOUT     6'h1c
`define SSDC_A_QCNT     6'h20
`define SSDC_A_IDS      6'h24
`define SSDC_A_SEL      6'h28
`define SSDC_A_PHASE    6'h2c
`define SSDC_THR_LO     6
`define SSDC_THR_HI     7
`define SSDC_THR_MODE_A 2'h3
`define SSDC_THR_MODE_B 2'h2
`define SSDC_THR_FAST   2'h0
`define SSDC_EV_STATUS  0
`define SSDC_EV_ABORT   1
`define SSDC_EV_LINK    2
`define SSDC_EV_SELIN   3
`define SSDC_HC_HALT    0
`define SSDC_HC_MODE    1
`define SSDC_AS_ARB     0
`define SSDC_AS_BSY     1
`define SSDC_AS_SEL     2
`define SSDC_VENDOR_ID  16'h5a5a
`define SSDC_DEVICE_ID  16'h0a0a
`endif

// ===== design/ssdc_pkg.sv
// Types for the selection validation and drive control block.
// Assumes the params header supplies all numeric constants.
package ssdc_pkg;
  typedef enum logic [1:0] {
    SSDC_SEL_OUT   = 2'b00,
    SSDC_SEL_IN    = 2'b01,
    SSDC_RESEL_OUT = 2'b10,
    SSDC_RESEL_IN  = 2'b11
  } ssdc_sel_kind_t;
  typedef enum logic [1:0] {
    SSDC_IDLE = 2'b00,
    SSDC_WAIT = 2'b01,
    SSDC_ACK  = 2'b10
  } ssdc_bus_st_t;
endpackage

// ===== tb/ssdc_core_props.sv
// Port checker for ssdc_core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ssdc_core_props (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        sel_valid,
  input wire logic [15:0] scsi_data_in,
  input wire logic        scsi_par_lo,
  input wire logic        scsi_par_hi,
  input wire logic        seq_status_done,
  input wire logic [7:0]  seq_status_byte,
  input wire logic        seq_bus_free,
  input wire logic        seq_halt,
  input wire logic        sel_respond,
  input wire logic        bsy_oe,
  input wire logic        io_oe,
  input wire logic [15:0] scsi_data_oe
);
  function automatic logic vld(logic [15:0] d, logic pl, logic ph);
    int lo;
    int hi;
    lo = $countones(d[7:0]);
    hi = $countones(d[15:8]);
    return (lo == 0 && pl && hi == 2 && ph) || (lo == 2 && pl && hi == 0) ||
      (lo == 1 && !pl && ((hi == 1 && !ph) || hi == 0));
  endfunction
  wire good = vld(scsi_data_in, scsi_par_lo, scsi_par_hi);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_ACK_ONE: assert property (take |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_RESP_OK: assert property (sel_valid && good |=> sel_respond)
    else $error("valid pattern ignored");
  AST_RESP_NO: assert property (sel_valid && !good |=> !sel_respond)
    else $error("invalid pattern answered");
  AST_HALT: assert property (seq_status_done && seq_status_byte != 8'h00 |=> seq_halt)
    else $error("no halt");
  AST_BSY_DRV: assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h0c
    |-> ##2 bsy_oe == $past(wb_dat_i[1], 2)) else $error("busy drive wrong");
  AST_IO_GATE: assert property (seq_bus_free && !sel_valid |=> !io_oe)
    else $error("io driven without role");
  AST_RST_CLR: assert property ($fell(reset) |-> !bsy_oe && !io_oe && scsi_data_oe == 16'h0)
    else $error("reset left drive on");
  cover property (sel_respond);
  cover property (seq_halt);
  cover property (bsy_oe);
endmodule
bind ssdc_core ssdc_core_props u_props (.*);

// ===== tb/ssdc_scsi_peer.sv
// Far-side SCSI device that presents selection patterns.
// Assumes the bench requests one pattern at a time through go.
`timescale 1ns/1ps
module ssdc_scsi_peer (
  input  wire logic                 sys_clk,
  input  wire logic                 go,
  input  wire logic [1:0]           kind,
  input  wire logic [17:0]          pat,
  output logic                      sel_valid,
  output ssdc_pkg::ssdc_sel_kind_t  sel_kind,
  output logic [15:0]               scsi_data_in,
  output logic                      scsi_par_lo,
  output logic                      scsi_par_hi
);
  initial begin
    sel_valid = 0;
    sel_kind = ssdc_pkg::SSDC_SEL_OUT;
    {scsi_par_hi, scsi_par_lo, scsi_data_in} = 18'h0;
  end
  always @(posedge sys_clk) begin
    sel_valid <= go;
    sel_kind <= ssdc_pkg::ssdc_sel_kind_t'(kind);
    // Released lines never keep the last value, so stale data cannot pass
    {scsi_par_hi, scsi_par_lo, scsi_data_in} <= go ? pat : ~{scsi_par_hi, scsi_par_lo, scsi_data_in};
  end
endmodule

// ===== tb/tb_ssdc_core.sv
// Self-checking bench for ssdc_core with a far-side SCSI peer.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ps
`include "ssdc_params.svh"
module tb_ssdc_core;
  logic sys_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, go = 0;
  logic [5:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf, own_id = 4'h5;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic seq_status_done = 0, seq_no_block = 0, seq_linked_done = 0, seq_q_push = 0;
  logic seq_sync_done = 0, seq_sync_fast = 0, seq_bus_free = 0;
  logic [7:0] seq_status_byte = 0, seq_q_data = 0;
  logic [1:0] kind = 0;
  logic [17:0] pat = 0;
  logic wb_ack_o, sel_valid, scsi_par_lo, scsi_par_hi, seq_halt, abort_msg_req, sel_respond;
  logic bsy_oe, sel_oe, req_oe, ack_oe, cd_oe, io_oe, msg_oe, io_dir;
  logic [15:0] scsi_data_in, scsi_data_out, scsi_data_oe;
  ssdc_pkg::ssdc_sel_kind_t sel_kind;
  int n_fail = 0, compares = 0, cyc_n = 0;
  typedef struct packed {logic [1:0] k; logic [17:0] p; logic r; logic [1:0] role;} ssdc_row_t;
  ssdc_row_t rows [6] = '{'{0, 18'h00101, 1, 1}, '{1, 18'h20002, 1, 2}, '{2, 18'h30300, 1, 2},
    '{3, 18'h10003, 1, 1}, '{1, 18'h10001, 0, 1}, '{2, 18'h20300, 0, 1}};
  ssdc_core DUT (.*);
  ssdc_scsi_peer u_peer (.*);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Compares %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 0;
    foreach (rows[i]) begin
      @(posedge sys_clk) {go, kind, pat} <= {1'b1, rows[i].k, rows[i].p};
      @(posedge sys_clk) go <= 0;
      @(posedge sys_clk) #1 chk(sel_respond, rows[i].r);
      wb(0, 6'h10, 0);
      chk(rd[1:0], rows[i].role);
    end
    wb(0, 6'h04, 0);
    chk(rd[7:6], 2'b11);
    wb(1, 6'h00, 32'h2);
    wb(0, 6'h04, 0);
    chk(rd[7:6], 2'b10);
    @(posedge sys_clk) {seq_sync_done, seq_sync_fast} <= 2'b11;
    @(posedge sys_clk) seq_sync_done <= 0;
    wb(0, 6'h04, 0);
    chk(rd[7:6], 2'b00);
    for (int b = 0; b < 4; b += 2) begin
      @(posedge sys_clk) {seq_status_done, seq_status_byte} <= {1'b1, 8'(b)};
      @(posedge sys_clk) seq_status_done <= 0;
      #1 chk(seq_halt, b != 0);
    end
    @(posedge sys_clk) {seq_no_block, seq_linked_done} <= 2'b11;
    @(posedge sys_clk) {seq_no_block, seq_linked_done} <= 2'b00;
    #1 chk(abort_msg_req, 1);
    wb(0, 6'h14, 0);
    chk(rd[2:0], 3'h7);
    wb(1, 6'h18, 32'hf);
    wb(0, 6'h14, 0);
    chk(rd[3:0], 4'h0);
    wb(1, 6'h00, 0);
    #1 chk(seq_halt, 0);
    @(posedge sys_clk) {seq_q_push, seq_q_data} <= {1'b1, 8'ha5};
    @(posedge sys_clk) seq_q_push <= 0;
    wb(0, 6'h20, 0);
    chk(rd, 1);
    wb(0, 6'h1c, 0);
    chk(rd[7:0], 8'ha5);
    wb(0, 6'h20, 0);
    chk(rd, 0);
    wb(0, 6'h24, 0);
    chk(rd, {`SSDC_DEVICE_ID, `SSDC_VENDOR_ID});
    wb(0, 6'h28, 0);
    chk(rd, 0);
    wb(1, 6'h08, 32'hf0);
    wb(0, 6'h08, 0);
    chk(rd[3:0], own_id);
    wb(1, 6'h0c, 32'h7);
    repeat (2) @(posedge sys_clk);
    #1 chk({bsy_oe, sel_oe}, 2'b11);
    chk({scsi_data_oe, scsi_data_out}, {2{16'h0020}});
    @(posedge sys_clk) seq_bus_free <= 1;
    @(posedge sys_clk) seq_bus_free <= 0;
    wb(1, 6'h2c, 32'h1f);
    repeat (3) @(posedge sys_clk);
    #1 chk({io_dir, io_oe, req_oe, ack_oe, cd_oe, msg_oe}, 6'h20);
    @(posedge sys_clk) {go, kind, pat} <= {1'b1, 2'd3, 18'h10003};
    @(posedge sys_clk) go <= 0;
    repeat (2) @(posedge sys_clk);
    #1 chk({io_dir, io_oe, req_oe, ack_oe, cd_oe, msg_oe}, 6'h34);
    @(posedge sys_clk) reset <= 1;
    repeat (4) @(posedge sys_clk);
    reset <= 0;
    #1 chk({seq_halt, bsy_oe, sel_oe, io_dir, scsi_data_oe}, 0);
    tally_and_finish();
  end
endmodule
